/* common/dio_pkg.sv */
package dio_pkg;

  localparam int PORT_LINES = 8;
  localparam int NUM_PORTS  = 14;
  localparam int NUM_LINES  = PORT_LINES * NUM_PORTS;
  localparam int TMO_W      = 32;

  // global port index of each connector's port 0
  localparam int CONN0_BASE = 0;
  localparam int CONN1_BASE = 2;
  localparam int CONN2_BASE = 7;
  localparam int TRIG_PORT  = 12;
  localparam int STAR_LINE  = 104;
  localparam int REF_LINE   = 105;

  localparam logic [7:0] OUT_BASE  = 8'h00;
  localparam logic [7:0] OE_BASE   = 8'h40;
  localparam logic [7:0] IN_BASE   = 8'h80;
  localparam logic [7:0] LINE_ACC  = 8'hc0;
  localparam logic [7:0] WAIT_CTRL = 8'hd0;
  localparam logic [7:0] WAIT_TMO  = 8'hd4;
  localparam logic [7:0] WAIT_RES  = 8'hd8;
  localparam logic [7:0] IRQ_STAT  = 8'he0;
  localparam logic [7:0] IRQ_MASK  = 8'he4;

  localparam logic [7:0]  OUT_RST  = 8'h00;
  localparam logic [7:0]  OE_RST   = 8'h00;
  localparam logic [31:0] TMO_RST  = 32'h0;
  localparam logic [31:0] TMO_LAST = 32'h1;

  // line access and wait control register fields
  localparam int LA_VAL   = 8;
  localparam int LA_OE    = 9;
  localparam int LA_SETV  = 12;
  localparam int LA_SETOE = 13;
  localparam int WC_MODE  = 8;

  localparam int IRQ_HIT = 0;
  localparam int IRQ_TMO = 1;

  typedef enum logic [2:0] {
    MODE_RISE = 3'h0,
    MODE_FALL = 3'h1,
    MODE_ANY  = 3'h2,
    MODE_HIGH = 3'h3,
    MODE_LOW  = 3'h4
  } wait_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } wait_state_type;

  typedef struct packed {
    wait_mode_type     mode;
    logic [TMO_W-1:0]  tmo;
  } wait_req_type;

  typedef struct packed {
    logic done;
    logic hit;
    logic timed_out;
  } wait_res_type;

endpackage

/* hdl/wait_engine.sv */
`timescale 1ns/1ps
module wait_engine
  import dio_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         start,
  input  wire wait_req_type req,
  input  wire logic         cur,
  input  wire logic         prev,
  output logic              busy,
  output wait_res_type      res
);

  wait_state_type   state;
  wait_mode_type    mode;
  logic             no_limit;
  logic [TMO_W-1:0] left;
  logic             cond;
  logic             expire;

  function automatic logic met(wait_mode_type m, logic c, logic p);
    case (m)
      MODE_RISE: met = c & ~p;
      MODE_FALL: met = ~c & p;
      MODE_ANY:  met = c ^ p;
      MODE_HIGH: met = c;
      MODE_LOW:  met = ~c;
      default:   met = 1'b0;
    endcase
  endfunction

  assign cond   = met(mode, cur, prev);
  assign busy   = (state == ST_WAIT);
  assign expire = !no_limit && (left == TMO_LAST);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      mode     <= MODE_RISE;
      no_limit <= 1'b0;
      left     <= TMO_RST;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            mode     <= req.mode;
            no_limit <= req.tmo[TMO_W-1];
            left     <= req.tmo;
            if (req.tmo != TMO_RST) begin
              state <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (cond || expire) begin
            state <= ST_IDLE;
          end else begin
            left <= left - TMO_LAST;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // condition wins over expiry in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      res <= '0;
    end else begin
      res.done <= 1'b0;
      if (!busy && start && req.tmo == TMO_RST) begin
        res <= '{done: 1'b1, hit: 1'b0, timed_out: 1'b1};
      end else if (busy && cond) begin
        res <= '{done: 1'b1, hit: 1'b1, timed_out: 1'b0};
      end else if (busy && expire) begin
        res <= '{done: 1'b1, hit: 1'b0, timed_out: 1'b1};
      end
    end
  end

  a_zero_tmo: assert property (@(posedge mclk) disable iff (!rstn)
    !busy && start && req.tmo == TMO_RST |=> res.done && res.timed_out && !busy)
    else $error("zero timeout did not end at once");
  a_neg_hold: assert property (@(posedge mclk) disable iff (!rstn)
    busy && no_limit && !cond |=> busy && !res.done)
    else $error("negative timeout released without condition");
  a_pos_expire: assert property (@(posedge mclk) disable iff (!rstn)
    !busy && start && req.tmo == 32'h3 ##1 !cond [*3] |=> res.timed_out)
    else $error("positive timeout miscounted");
  a_rise_wait: assert property (@(posedge mclk) disable iff (!rstn)
    busy && mode == MODE_RISE && cur && !prev |=> res.done && res.hit)
    else $error("rising edge missed");
  a_fall_wait: assert property (@(posedge mclk) disable iff (!rstn)
    busy && mode == MODE_FALL && !cur && prev |=> res.done && res.hit)
    else $error("falling edge missed");
  a_any_wait: assert property (@(posedge mclk) disable iff (!rstn)
    busy && mode == MODE_ANY && cur == prev && !expire |=> busy)
    else $error("any edge wait released early");
  a_high_wait: assert property (@(posedge mclk) disable iff (!rstn)
    busy && mode == MODE_HIGH && cur |=> !busy && res.hit)
    else $error("high level not released");
  a_low_wait: assert property (@(posedge mclk) disable iff (!rstn)
    busy && mode == MODE_LOW && cur && !expire |=> busy)
    else $error("low level wait released while high");

  c_hit: cover property (@(posedge mclk) res.done && res.hit);
  c_tmo: cover property (@(posedge mclk) busy ##1 res.done && res.timed_out);
  c_zero: cover property (@(posedge mclk) !busy && start && req.tmo == 32'h0);

endmodule

/* hdl/dio_block.sv */
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module dio_block
  import dio_pkg::*;
#(
  parameter int NPORT = NUM_PORTS
)
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic [8*NPORT-1:0]    io_line_in,
  output logic [8*NPORT-1:0]         io_line_out,
  output logic [8*NPORT-1:0]         io_line_oe_n,
  input  wire logic                  ref_clk_in,
  input  wire logic                  timing_slot,
  output logic                       irq
);

  localparam int NL = 8 * NPORT;

  logic [NL-1:0]    out_val;
  logic [NL-1:0]    out_en;
  logic [NL-1:0]    in_now;
  logic [NL-1:0]    in_old;
  logic [NL-1:0]    pin_sample;
  logic [6:0]       line_sel;
  logic [6:0]       wait_line;
  logic [TMO_W-1:0] wait_tmo;
  logic [1:0]       irq_stat;
  logic [1:0]       irq_mask;

  logic             accept;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             stat_wait;
  logic             busy;
  logic             start;
  wait_req_type     req;
  wait_res_type     res;

  // the reference clock joins the line model on a spare read-only slot
  always_comb begin
    pin_sample           = io_line_in;
    pin_sample[REF_LINE] = ref_clk_in;
    for (int i = REF_LINE + 1; i < NL; i++) begin
      pin_sample[i] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      in_now <= '0;
      in_old <= '0;
    end else begin
      in_now <= pin_sample;
      in_old <= in_now;
    end
  end

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;
  assign hresp  = 1'b0;

  // the status read holds the caller while a wait runs
  assign hreadyout = !stat_wait;

  function automatic logic [31:0] read_word(logic [31:0] a);
    logic [3:0]  idx;
    logic [31:0] w;
    idx = a[5:2];
    w   = 32'h0;
    if (a[31:8] != 24'h0) begin
      w = 32'h0;
    end else if (a[7:6] == OUT_BASE[7:6] && idx < NPORT) begin
      w[7:0] = out_val[{idx, 3'b000} +: 8];
    end else if (a[7:6] == OE_BASE[7:6] && idx < NPORT) begin
      w[7:0] = out_en[{idx, 3'b000} +: 8];
    end else if (a[7:6] == IN_BASE[7:6] && idx < NPORT) begin
      w[7:0] = in_now[{idx, 3'b000} +: 8];
    end else if (a[7:0] == LINE_ACC) begin
      w[0]     = in_now[line_sel];
      w[LA_VAL] = out_val[line_sel];
      w[LA_OE]  = out_en[line_sel];
      w[22:16]  = line_sel;
    end else if (a[7:0] == WAIT_TMO) begin
      w = wait_tmo;
    end else if (a[7:0] == WAIT_RES) begin
      w[2:0] = {res.timed_out, res.hit, busy};
    end else if (a[7:0] == IRQ_STAT) begin
      w[1:0] = irq_stat;
    end else if (a[7:0] == IRQ_MASK) begin
      w[1:0] = irq_mask;
    end
    return w;
  endfunction

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= accept && hwrite && (haddr[31:8] == 24'h0);
      wr_addr <= haddr[7:0];
    end
  end

  // read data is re-sampled every stalled cycle so it leaves fresh
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hrdata    <= 32'h0;
      stat_wait <= 1'b0;
    end else if (stat_wait) begin
      hrdata <= read_word({24'h0, WAIT_RES});
      if (!busy) begin
        stat_wait <= 1'b0;
      end
    end else if (accept && !hwrite) begin
      hrdata    <= read_word(haddr);
      stat_wait <= (haddr == {24'h0, WAIT_RES});
    end
  end

  // ------------------------------------------------------------------
  // output value and enable storage
  // ------------------------------------------------------------------
  // byte access per port
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      out_val  <= {NPORT{OUT_RST}};
      out_en   <= {NPORT{OE_RST}};
      line_sel <= 7'h00;
    end else if (wr_pend) begin
      if (wr_addr[7:6] == OUT_BASE[7:6] && wr_addr[5:2] < NPORT) begin
        out_val[{wr_addr[5:2], 3'b000} +: 8] <= hwdata[7:0];
      end else if (wr_addr[7:6] == OE_BASE[7:6]
                   && wr_addr[5:2] < NPORT) begin
        out_en[{wr_addr[5:2], 3'b000} +: 8] <= hwdata[7:0];
      end else if (wr_addr == LINE_ACC) begin
        // line path; software keeps it apart from the port path
        line_sel <= hwdata[6:0];
        if (hwdata[LA_SETV]) begin
          out_val[hwdata[6:0]] <= hwdata[LA_VAL];
        end
        if (hwdata[LA_SETOE]) begin
          out_en[hwdata[6:0]] <= hwdata[LA_OE];
        end
      end
    end
  end

  assign io_line_out = out_val;

  // port k drives lines 8k..8k+7, lowest line in bit 0
  for (genvar k = 0; k < NPORT; k++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_bit
      // one process per pin keeps every driven bit a constant select
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          io_line_oe_n[8*k + b] <= 1'b1;
        end else if (8*k + b > STAR_LINE) begin
          // reference slot and spares never driven
          io_line_oe_n[8*k + b] <= 1'b1;
        end else if (8*k + b == STAR_LINE) begin
          io_line_oe_n[8*k + b] <= !out_en[8*k + b] || timing_slot;
        end else begin
          io_line_oe_n[8*k + b] <= !out_en[8*k + b];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // wait operations
  // ------------------------------------------------------------------
  assign start    = wr_pend && (wr_addr == WAIT_CTRL) && !busy;
  assign req      = '{mode: wait_mode_type'(hwdata[WC_MODE +: 3]),
                      tmo:  wait_tmo};

  // a new wait while one runs is dropped; the line stays as before
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_line <= 7'h00;
      wait_tmo  <= TMO_RST;
    end else begin
      if (start) begin
        wait_line <= hwdata[6:0];
      end
      if (wr_pend && wr_addr == WAIT_TMO) begin
        wait_tmo <= hwdata;
      end
    end
  end

  wait_engine u_wait (
    .mclk  (mclk),
    .rstn  (rstn),
    .start (start),
    .req   (req),
    .cur   (in_now[wait_line]),
    .prev  (in_old[wait_line]),
    .busy  (busy),
    .res   (res)
  );

  // ------------------------------------------------------------------
  // interrupts: sticky, write one to clear, a new event beats the clear
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      if (wr_pend && wr_addr == IRQ_MASK) begin
        irq_mask <= hwdata[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (wr_pend && wr_addr == IRQ_STAT && hwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
      if (res.done && res.hit) begin
        irq_stat[IRQ_HIT] <= 1'b1;
      end
      if (res.done && res.timed_out) begin
        irq_stat[IRQ_TMO] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_port_byte: assert property (@(posedge mclk) disable iff (!rstn)
    wr_pend && wr_addr == OUT_BASE + 8'h04
    |=> io_line_out[15:8] == $past(hwdata[7:0]))
    else $error("port write did not reach its eight lines");
  a_line_bit: assert property (@(posedge mclk) disable iff (!rstn)
    wr_pend && wr_addr == LINE_ACC && hwdata[LA_SETOE]
    && hwdata[6:0] == 7'h3c && !timing_slot
    |=> ##1 io_line_oe_n[60] == !$past(hwdata[LA_OE], 2))
    else $error("line enable did not reach its pin");
  a_ref_input: assert property (@(posedge mclk) disable iff (!rstn)
    io_line_oe_n[REF_LINE])
    else $error("reference clock slot driven");
  a_star_slot: assert property (@(posedge mclk) disable iff (!rstn)
    timing_slot |=> io_line_oe_n[STAR_LINE])
    else $error("star driven in timing slot");
  a_stall_busy: assert property (@(posedge mclk) disable iff (!rstn)
    stat_wait && busy |=> !hreadyout)
    else $error("caller released while wait busy");

  c_stall: cover property (@(posedge mclk) stat_wait ##1 hreadyout);
  c_irq: cover property (@(posedge mclk) irq);

endmodule

/* testbench/pin_model.sv */
`timescale 1ns/1ps
module pin_model
  import dio_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic [NUM_LINES-1:0] line_out,
  input  wire logic [NUM_LINES-1:0] line_oe_n,
  input  wire logic [NUM_LINES-1:0] ext_val,
  input  wire logic [NUM_LINES-1:0] ext_en,
  output logic      [NUM_LINES-1:0] line_in,
  output logic                      ref_clk
);
  logic [NUM_LINES-1:0] float_v = '0;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // nobody drives: level wanders, so a stale value never reads as valid
  always @(posedge mclk) begin
    float_v <= ~float_v;
  end

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      if (!line_oe_n[i])
        line_in[i] = line_out[i];
      else if (ext_en[i])
        line_in[i] = ext_val[i];
      else
        line_in[i] = float_v[i];
    end
  end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import dio_pkg::*;
;
  logic                 mclk;
  logic                 rstn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic                 hready;
  logic                 hreadyout;
  logic                 hresp;
  logic [31:0]          hrdata;
  logic [NUM_LINES-1:0] io_line_in;
  logic [NUM_LINES-1:0] io_line_out;
  logic [NUM_LINES-1:0] io_line_oe_n;
  logic [NUM_LINES-1:0] ext_val;
  logic [NUM_LINES-1:0] ext_en;
  logic                 ref_clk_in;
  logic                 timing_slot;
  logic                 irq;
  int                   n_errors;
  int                   tests_run;

  assign hready = hreadyout;

  dio_block dut_u (
    .mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .io_line_in(io_line_in),
    .io_line_out(io_line_out), .io_line_oe_n(io_line_oe_n),
    .ref_clk_in(ref_clk_in), .timing_slot(timing_slot), .irq(irq)
  );

  pin_model far_u (
    .mclk(mclk), .line_out(io_line_out), .line_oe_n(io_line_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .line_in(io_line_in),
    .ref_clk(ref_clk_in)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  // each phase holds until hready is seen high at a rising edge
  task automatic ahb_xfer(input logic [31:0] a, input logic wr,
                          input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge mclk);
    while (!hready) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (!hready) @(posedge mclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb_xfer({24'h0, a}, 1'b1, d, dummy);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb_xfer(a, 1'b0, 32'h0, r);
    check(r, exp);
    check({31'h0, hresp}, 32'h0);
  endtask

  // line 40 sits on a port the device leaves released
  task automatic wait_case(input logic [2:0] mode, input logic [31:0] tmo,
                           input logic lv0, input logic lv1, input int dly,
                           input logic [2:0] exp, input int lo,
                           input int hi);
    logic [31:0] r;
    realtime     t0;
    int          cyc;
    ext_val[40] <= lv0;
    repeat (3) @(posedge mclk);
    wr(WAIT_TMO, tmo);
    wr(WAIT_CTRL, {21'h0, mode, 8'h28});
    t0 = $realtime;
    fork
      ahb_xfer({24'h0, WAIT_RES}, 1'b0, 32'h0, r);
      begin
        repeat (dly) @(posedge mclk);
        ext_val[40] <= lv1;
      end
    join
    cyc = int'(($realtime - t0) / 25.0);
    check(r, {29'h0, exp});
    check({31'h0, cyc >= lo && cyc <= hi}, 32'h1);
  endtask

  task automatic t_reset();
    check({31'h0, hreadyout}, 32'h1);
    check({31'h0, irq}, 32'h0);
    check({31'h0, |io_line_out}, 32'h0);
    check({31'h0, &io_line_oe_n}, 32'h1);
  endtask

  task automatic t_reset_mid();
    wr(OE_BASE, 32'hff);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    check({31'h0, &io_line_oe_n}, 32'h1);
    check({31'h0, |io_line_out}, 32'h0);
    check(hrdata, 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk(32'(OUT_BASE), 32'h0);
  endtask

  task automatic t_ports();
    int p;
    int q[4] = '{0, 1, 6, 11};
    foreach (q[i]) begin
      p = q[i];
      // these lines only ever through their port
      wr(OUT_BASE + 8'(4 * p), 32'(8'h11 * (p + 1)));
      wr(OE_BASE + 8'(4 * p), 32'hff);
      repeat (3) @(posedge mclk);
      check(32'(io_line_out[8*p +: 8]), 32'(8'h11 * (p + 1)));
      check(32'(io_line_oe_n[8*p +: 8]), 32'h0);
      rd_chk(32'(IN_BASE) + 32'(4 * p), 32'(8'h11 * (p + 1)));
    end
  endtask

  task automatic t_line();
    wr(LINE_ACC, 32'h333c);
    repeat (3) @(posedge mclk);
    check({30'h0, io_line_out[60], io_line_oe_n[60]}, 32'h2);
    rd_chk(32'(LINE_ACC), 32'h003c0301);
    rd_chk(32'h100, 32'h0);
  endtask

  task automatic t_star();
    // star use in timing slot is refused
    timing_slot <= 1'b1;
    wr(OUT_BASE + 8'h34, 32'h3);
    wr(OE_BASE + 8'h34, 32'h3);
    repeat (3) @(posedge mclk);
    check(32'(io_line_oe_n[105:104]), 32'h3);
    timing_slot <= 1'b0;
    repeat (3) @(posedge mclk);
    check(32'(io_line_oe_n[105:104]), 32'h2);
    wr(OE_BASE + 8'h34, 32'h0);
  endtask

  task automatic t_waits();
    wait_case(MODE_RISE, 32'hffffffff, 0, 1, 60, 3'h2, 60, 70);
    wait_case(MODE_FALL, 32'd100, 1, 0, 10, 3'h2, 10, 20);
    wait_case(MODE_ANY, 32'd100, 0, 1, 10, 3'h2, 10, 20);
    wait_case(MODE_HIGH, 32'd100, 0, 1, 10, 3'h2, 10, 20);
    wait_case(MODE_LOW, 32'd100, 1, 0, 10, 3'h2, 10, 20);
    wait_case(MODE_HIGH, 32'd100, 1, 1, 1, 3'h2, 1, 8);
    wait_case(MODE_RISE, 32'd20, 1, 1, 1, 3'h4, 18, 25);
    wait_case(MODE_HIGH, 32'd0, 0, 0, 1, 3'h4, 1, 6);
  endtask

  task automatic t_irq();
    wr(IRQ_STAT, 32'h3);
    wr(IRQ_MASK, 32'h1);
    wait_case(MODE_RISE, 32'd3, 0, 0, 1, 3'h4, 4, 6);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    rd_chk(32'(IRQ_STAT), 32'h2);
    wait_case(MODE_LOW, 32'd100, 0, 0, 1, 3'h2, 1, 8);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    wr(IRQ_STAT, 32'h3);
    repeat (3) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    rd_chk(32'(IRQ_STAT), 32'h0);
  endtask

  initial begin
    n_errors    = 0;
    tests_run   = 0;
    rstn        = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    timing_slot = 1'b0;
    ext_val     = '0;
    ext_en      = '0;
    ext_en[40]  = 1'b1;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_ports();
    t_line();
    t_star();
    t_waits();
    t_irq();
    t_reset_mid();
    wrap_up();
  end

  // whole run is well under a thousand cycles
  initial begin
    #(25 * 5000);
    n_errors++;
    wrap_up();
  end
endmodule
